// [rtl/dpu_pkg.sv]
package dpu_pkg;

  localparam logic [7:0] ADDR_PTR0_LO = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HI = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LO = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HI = 8'h85;
  localparam logic [7:0] ADDR_PCFG = 8'ha2;
  localparam logic [7:0] ADDR_SPC = 8'he2;

  localparam logic [7:0] PREFIX_OPCODE = 8'ha5;

  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] PCFG_RESET = 8'h00;
  localparam logic [7:0] SPC_RESET = 8'h00;

  // Pointer configuration register fields
  localparam int PCFG_SEL_BIT = 0;
  localparam int PCFG_ZERO_BIT = 2;

  // Signal-processing configuration fields
  localparam int SPC_REDIRECT_BIT = 0;
  localparam int SPC_IDXDIS_BIT = 1;
  localparam int SPC_CIRC0_BIT = 2;
  localparam int SPC_CIRC1_BIT = 3;
  localparam int SPC_ACC_SIGN_BIT = 4;
  localparam int SPC_B_SIGN_BIT = 5;
  localparam int SPC_WIN_LSB = 6;

  typedef enum logic [2:0] {
    OP_LOAD = 3'h0,
    OP_INC = 3'h1,
    OP_MOVC = 3'h2,
    OP_MOVX_RD = 3'h3,
    OP_MOVX_WR = 3'h4,
    OP_JMP = 3'h5
  } dpu_op_kind_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpu_sfr_req_t;

  typedef struct packed {
    logic valid;
    logic inverted;
    dpu_op_kind_t kind;
    logic [15:0] imm;
    logic [7:0] acc;
  } dpu_op_req_t;

  typedef struct packed {
    logic [15:0] start_addr;
    logic [15:0] end_addr;
  } dpu_range_t;

endpackage

// [rtl/dpu_circ_step.sv]
`timescale 1ns/1ps
module dpu_circ_step (
  input wire logic [15:0] ptr_in,
  input wire logic circ_en_in,
  input wire dpu_pkg::dpu_range_t [1:0] range_in,
  output logic [15:0] next_out,
  output logic wrap_out
);

  logic [1:0] hit;

  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_range
      assign hit[k] = circ_en_in && (ptr_in == range_in[k].end_addr);
    end
  endgenerate

  // Range 0 wins if both buffers share an end bound
  always_comb
  begin
    next_out = ptr_in + 16'h0001;
    wrap_out = |hit;
    if (hit[0])
    begin
      next_out = range_in[0].start_addr;
    end
    else if (hit[1])
    begin
      next_out = range_in[1].start_addr;
    end
  end

endmodule

// [rtl/dpu_top.sv]
// How it works
// - Two 16-bit pointers, byte registers at 82h/83h and 84h/85h.
// - Generic pointer operand goes to the pointer chosen by the select bit.
// - Select 0: generic is pointer zero, inverted is one; select 1 swaps.
// - Direct byte register access reaches its pointer whatever the select bit.
// - Configuration bit 2 reads zero so incrementing toggles the select bit.
// - Prefix opcode a5h inverts the select for the next instruction only.
// - Indirect jump always uses the plain select bit, prefix ignored.
// - Two-bit window field picks the accumulator byte pair shown at e4h/e5h.
// - B sign bit makes 8x8 multiply treat B as signed; MAC unaffected.
// - ACC sign bit makes 8x8 multiply treat ACC as signed; MAC unaffected.
// - Circular enable one puts pointer one into circular addressing.
// - Circular enable zero puts pointer zero into circular addressing.
// - Index disable drops the accumulator offset from indexed code reads.
// - Redirect bit moves pointer-one data transfers from ACC to B.
`timescale 1ns/1ps
module dpu_top (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire dpu_pkg::dpu_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic insn_first_in,
  input wire logic [7:0] opcode_in,
  input wire dpu_pkg::dpu_op_req_t op_req_in,
  input wire dpu_pkg::dpu_range_t [1:0] cb_range_in,
  output logic [15:0] addr_out,
  output logic addr_valid_out,
  output logic ptr_sel_out,
  output logic use_b_out,
  output logic mul_signed_a_out,
  output logic mul_signed_b_out,
  output logic [1:0] mac_window_out
);

  logic [1:0][15:0] ptr_r;
  logic [7:0] pcfg_r;
  logic [7:0] spc_r;
  logic prefix_pend_r;
  logic prefix_act_r;
  logic [1:0][15:0] step_next;
  logic [1:0] step_wrap;
  logic pointer_select_bit;
  logic sel;
  logic [15:0] sel_ptr;
  logic is_jmp;
  logic is_xfer;

  assign pointer_select_bit = pcfg_r[dpu_pkg::PCFG_SEL_BIT];
  assign is_jmp = op_req_in.kind == dpu_pkg::OP_JMP;
  assign is_xfer = op_req_in.kind == dpu_pkg::OP_MOVC || op_req_in.kind == dpu_pkg::OP_MOVX_RD
    || op_req_in.kind == dpu_pkg::OP_MOVX_WR;
  // Jump never honours the prefix
  assign sel = is_jmp ? pointer_select_bit
    : (pointer_select_bit ^ prefix_act_r);
  assign sel_ptr = ptr_r[sel];

  // Prefix only reaches the instruction right after it; a5h a5h keeps it pending
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      prefix_pend_r <= 1'b0;
      prefix_act_r <= 1'b0;
    end
    else if (insn_first_in)
    begin
      if (opcode_in == dpu_pkg::PREFIX_OPCODE)
      begin
        prefix_pend_r <= 1'b1;
      end
      else
      begin
        prefix_pend_r <= 1'b0;
        prefix_act_r <= prefix_pend_r;
      end
    end
  end

  // Bit 2 never stores, so an increment of the register flips the select bit and never carries into bits 3 to 7
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      pcfg_r <= dpu_pkg::PCFG_RESET;
    end
    else if (sfr_req_in.wr && sfr_req_in.addr == dpu_pkg::ADDR_PCFG)
    begin
      pcfg_r <= sfr_req_in.wdata;
      pcfg_r[dpu_pkg::PCFG_ZERO_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      spc_r <= dpu_pkg::SPC_RESET;
    end
    else if (sfr_req_in.wr && sfr_req_in.addr == dpu_pkg::ADDR_SPC)
    begin
      spc_r <= sfr_req_in.wdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_ptr
      localparam logic [7:0] LO = (i == 0) ? dpu_pkg::ADDR_PTR0_LO : dpu_pkg::ADDR_PTR1_LO;
      localparam logic [7:0] HI = (i == 0) ? dpu_pkg::ADDR_PTR0_HI : dpu_pkg::ADDR_PTR1_HI;
      localparam int CBIT = (i == 0) ? dpu_pkg::SPC_CIRC0_BIT : dpu_pkg::SPC_CIRC1_BIT;

      dpu_circ_step u_step (
        .ptr_in(ptr_r[i]),
        .circ_en_in(spc_r[CBIT]),
        .range_in(cb_range_in),
        .next_out(step_next[i]),
        .wrap_out(step_wrap[i])
      );

      // Instruction update beats a same-cycle byte write
      always_ff @(posedge mclk_in)
      begin
        if (srst_in)
        begin
          ptr_r[i] <= dpu_pkg::PTR_RESET;
        end
        else if (op_req_in.valid && sel == 1'(i) && op_req_in.kind == dpu_pkg::OP_LOAD)
        begin
          ptr_r[i] <= op_req_in.imm;
        end
        else if (op_req_in.valid && sel == 1'(i) && op_req_in.kind == dpu_pkg::OP_INC)
        begin
          ptr_r[i] <= step_next[i];
        end
        else if (sfr_req_in.wr && sfr_req_in.addr == LO)
        begin
          ptr_r[i][7:0] <= sfr_req_in.wdata;
        end
        else if (sfr_req_in.wr && sfr_req_in.addr == HI)
        begin
          ptr_r[i][15:8] <= sfr_req_in.wdata;
        end
      end
    end
  endgenerate

  // Window bytes themselves live with the accumulator; unmapped reads give zero
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      sfr_rdata_out <= 8'h00;
    end
    else if (sfr_req_in.rd)
    begin
      case (sfr_req_in.addr)
        dpu_pkg::ADDR_PTR0_LO: sfr_rdata_out <= ptr_r[0][7:0];
        dpu_pkg::ADDR_PTR0_HI: sfr_rdata_out <= ptr_r[0][15:8];
        dpu_pkg::ADDR_PTR1_LO: sfr_rdata_out <= ptr_r[1][7:0];
        dpu_pkg::ADDR_PTR1_HI: sfr_rdata_out <= ptr_r[1][15:8];
        dpu_pkg::ADDR_PCFG: sfr_rdata_out <= pcfg_r;
        dpu_pkg::ADDR_SPC: sfr_rdata_out <= spc_r;
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
    else
    begin
      sfr_rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      addr_out <= 16'h0000;
      addr_valid_out <= 1'b0;
      ptr_sel_out <= 1'b0;
      use_b_out <= 1'b0;
    end
    else
    begin
      addr_valid_out <= op_req_in.valid && (is_xfer || is_jmp);
      ptr_sel_out <= op_req_in.valid ? sel : ptr_sel_out;
      use_b_out <= op_req_in.valid && is_xfer && sel
        && spc_r[dpu_pkg::SPC_REDIRECT_BIT];
      if (op_req_in.valid)
      begin
        case (op_req_in.kind)
          dpu_pkg::OP_MOVC:
          begin
            addr_out <= spc_r[dpu_pkg::SPC_IDXDIS_BIT] ? sel_ptr
              : sel_ptr + {8'h00, op_req_in.acc};
          end
          dpu_pkg::OP_JMP: addr_out <= sel_ptr + {8'h00, op_req_in.acc};
          default: addr_out <= sel_ptr;
        endcase
      end
    end
  end

  // Operand sign and window flags go to the multiplier and accumulator
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      mul_signed_a_out <= 1'b0;
      mul_signed_b_out <= 1'b0;
      mac_window_out <= 2'h0;
    end
    else
    begin
      mul_signed_a_out <= spc_r[dpu_pkg::SPC_ACC_SIGN_BIT];
      mul_signed_b_out <= spc_r[dpu_pkg::SPC_B_SIGN_BIT];
      mac_window_out <= spc_r[dpu_pkg::SPC_WIN_LSB +: 2];
    end
  end

  default clocking cb_main @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_spc_write;
    sfr_req_in.wr && sfr_req_in.addr == dpu_pkg::ADDR_SPC;
  endsequence

  sequence s_op(dpu_pkg::dpu_op_kind_t k);
    op_req_in.valid && op_req_in.kind == k;
  endsequence

  property p_pcfg_bit2;
    sfr_req_in.rd && sfr_req_in.addr == dpu_pkg::ADDR_PCFG |=> !sfr_rdata_out[2];
  endproperty
  a_pcfg_bit2: assert property (p_pcfg_bit2) else $error("cfg bit 2 read as one");

  property p_sel_map;
    op_req_in.valid && !is_jmp
      |=> ptr_sel_out == ($past(pointer_select_bit) ^ $past(prefix_act_r));
  endproperty
  a_sel_map: assert property (p_sel_map) else $error("pointer mapping wrong");

  property p_jmp_plain;
    s_op(dpu_pkg::OP_JMP) |=> ptr_sel_out == $past(pointer_select_bit) && addr_valid_out;
  endproperty
  a_jmp_plain: assert property (p_jmp_plain) else $error("jump used inverted select");

  property p_prefix_next;
    insn_first_in && opcode_in == dpu_pkg::PREFIX_OPCODE ##1
      insn_first_in && opcode_in != dpu_pkg::PREFIX_OPCODE |=> prefix_act_r;
  endproperty
  a_prefix_next: assert property (p_prefix_next) else $error("prefix not applied");

  property p_redirect;
    (s_op(dpu_pkg::OP_MOVX_RD) or s_op(dpu_pkg::OP_MOVX_WR) or s_op(dpu_pkg::OP_MOVC))
      |=> use_b_out == ($past(sel) && $past(spc_r[dpu_pkg::SPC_REDIRECT_BIT]));
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirect to B wrong");

  property p_noindex;
    s_op(dpu_pkg::OP_MOVC) ##0 spc_r[dpu_pkg::SPC_IDXDIS_BIT]
      |=> addr_out == $past(sel_ptr);
  endproperty
  a_noindex: assert property (p_noindex) else $error("index not disabled");

  property p_mul_sign;
    s_spc_write |-> ##2 mul_signed_b_out == $past(sfr_req_in.wdata[dpu_pkg::SPC_B_SIGN_BIT], 2)
      && mul_signed_a_out == $past(sfr_req_in.wdata[dpu_pkg::SPC_ACC_SIGN_BIT], 2);
  endproperty
  a_mul_sign: assert property (p_mul_sign) else $error("multiply sign flags wrong");

  property p_wrap;
    s_op(dpu_pkg::OP_INC) ##0 (!sel && spc_r[dpu_pkg::SPC_CIRC0_BIT]
      && ptr_r[0] == cb_range_in[0].end_addr)
      |=> $past(step_wrap[0]) && ptr_r[0] == $past(cb_range_in[0].start_addr);
  endproperty
  a_wrap: assert property (p_wrap) else $error("circular wrap wrong");

  property p_direct_rd;
    sfr_req_in.rd && sfr_req_in.addr == dpu_pkg::ADDR_PTR1_LO
      |=> sfr_rdata_out == $past(ptr_r[1][7:0]);
  endproperty
  a_direct_rd: assert property (p_direct_rd) else $error("direct pointer read wrong");

endmodule

// [test/dpu_cpu_model.sv]
`timescale 1ns/1ps
module dpu_cpu_model (
  input wire logic clk_in,
  output logic insn_first_out,
  output logic [7:0] opcode_out,
  output dpu_pkg::dpu_op_req_t op_req_out
);
  initial
  begin
    insn_first_out = 1'b0;
    opcode_out = 8'h00;
    op_req_out = '0;
  end
  // Optional prefix byte, first byte, then the operation a cycle later
  task automatic issue(input logic pre, input dpu_pkg::dpu_op_kind_t kind,
    input logic [15:0] imm, input logic [7:0] acc);
    if (pre)
    begin
      @(negedge clk_in);
      insn_first_out = 1'b1;
      opcode_out = dpu_pkg::PREFIX_OPCODE;
    end
    @(negedge clk_in);
    insn_first_out = 1'b1;
    opcode_out = 8'h3c;
    @(negedge clk_in);
    insn_first_out = 1'b0;
    opcode_out = ~opcode_out;
    op_req_out = {1'b1, pre, kind, imm, acc};
    @(negedge clk_in);
    // Idle fields flip so stale values never pass for live ones
    op_req_out = {1'b0, 1'b0, kind, ~imm, ~acc};
  endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic sel;
    logic pre;
    dpu_pkg::dpu_op_kind_t kind;
    logic [7:0] spc;
    logic [7:0] acc;
    logic [15:0] exp_addr;
    logic exp_sel;
    logic exp_b;
  } dpu_row_t;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  dpu_pkg::dpu_sfr_req_t sfr = '0;
  dpu_pkg::dpu_range_t [1:0] rng;
  dpu_pkg::dpu_op_req_t op;
  logic first, valid, psel, useb, sga, sgb;
  logic [7:0] opc, rdata, rd_b;
  logic [15:0] addr, w, ea;
  logic [1:0] win;
  int error_cnt = 0;
  int tests_run = 0;
  dpu_row_t rows[10] = '{
    '{1'b0, 1'b0, dpu_pkg::OP_MOVC, 8'h00, 8'h10, 16'h1300, 1'b0, 1'b0},
    '{1'b0, 1'b1, dpu_pkg::OP_MOVC, 8'h40, 8'h10, 16'h8010, 1'b1, 1'b0},
    '{1'b1, 1'b0, dpu_pkg::OP_MOVX_RD, 8'h81, 8'h33, 16'h8000, 1'b1, 1'b1},
    '{1'b1, 1'b1, dpu_pkg::OP_MOVX_WR, 8'hc1, 8'h33, 16'h12f0, 1'b0, 1'b0},
    '{1'b0, 1'b1, dpu_pkg::OP_MOVX_WR, 8'h31, 8'h00, 16'h8000, 1'b1, 1'b1},
    '{1'b1, 1'b0, dpu_pkg::OP_MOVC, 8'h12, 8'h20, 16'h8000, 1'b1, 1'b0},
    '{1'b1, 1'b1, dpu_pkg::OP_JMP, 8'h21, 8'h05, 16'h8005, 1'b1, 1'b0},
    '{1'b0, 1'b1, dpu_pkg::OP_JMP, 8'he2, 8'h05, 16'h12f5, 1'b0, 1'b0},
    '{1'b0, 1'b0, dpu_pkg::OP_MOVC, 8'h03, 8'h20, 16'h12f0, 1'b0, 1'b0},
    '{1'b1, 1'b0, dpu_pkg::OP_MOVC, 8'h51, 8'h20, 16'h8020, 1'b1, 1'b1}};
  always #5 mclk_in = ~mclk_in;
  dpu_top dut (.mclk_in(mclk_in), .srst_in(srst_in), .sfr_req_in(sfr), .sfr_rdata_out(rdata),
    .insn_first_in(first), .opcode_in(opc), .op_req_in(op), .cb_range_in(rng),
    .addr_out(addr), .addr_valid_out(valid), .ptr_sel_out(psel), .use_b_out(useb),
    .mul_signed_a_out(sga), .mul_signed_b_out(sgb), .mac_window_out(win));
  dpu_cpu_model cpu (.clk_in(mclk_in), .insn_first_out(first), .opcode_out(opc),
    .op_req_out(op));
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sfr_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    sfr = {~wr, wr, a, d};
    @(negedge mclk_in);
    rd_b = rdata;
    sfr = {2'b00, ~a, ~d};
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    sfr_acc(1'b0, a, 8'h00);
    v[7:0] = rd_b;
    sfr_acc(1'b0, a + 8'h01, 8'h00);
    v[15:8] = rd_b;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    sfr_acc(1'b1, a, v[7:0]);
    sfr_acc(1'b1, a + 8'h01, v[15:8]);
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    error_cnt++;
    complete_run;
  end
  initial
  begin
    rng[0] = {16'h0100, 16'h0103};
    rng[1] = {16'h0200, 16'h0207};
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    srst_in = 1'b0;
    chk("out_rst", addr | {valid, psel, useb, sga, sgb, win, 9'h000}, 16'h0000);
    sfr_acc(1'b0, dpu_pkg::ADDR_SPC, 8'h00);
    chk("spc_rst", {8'h00, rd_b}, 16'h0000);
    sfr_acc(1'b1, 8'h86, 8'hff);
    sfr_acc(1'b0, 8'h86, 8'h00);
    chk("unmapped", {8'h00, rd_b}, 16'h0000);
    sfr_acc(1'b1, dpu_pkg::ADDR_PCFG, 8'hff);
    sfr_acc(1'b0, dpu_pkg::ADDR_PCFG, 8'h00);
    chk("pcfg", {8'h00, rd_b}, 16'h00fb);
    // Select is 1 here, so direct byte access must ignore it
    wr16(dpu_pkg::ADDR_PTR0_LO, 16'h12f0);
    wr16(dpu_pkg::ADDR_PTR1_LO, 16'h8000);
    rd16(dpu_pkg::ADDR_PTR0_LO, w);
    chk("ptr0", w, 16'h12f0);
    rd16(dpu_pkg::ADDR_PTR1_LO, w);
    chk("ptr1", w, 16'h8000);
    foreach (rows[i])
    begin
      sfr_acc(1'b1, dpu_pkg::ADDR_PCFG, {7'h00, rows[i].sel});
      sfr_acc(1'b1, dpu_pkg::ADDR_SPC, rows[i].spc);
      cpu.issue(rows[i].pre, rows[i].kind, 16'h0000, rows[i].acc);
      chk("addr", addr, rows[i].exp_addr);
      chk("valid", {15'h0000, valid}, 16'h0001);
      chk("ptr_sel", {15'h0000, psel}, {15'h0000, rows[i].exp_sel});
      chk("use_b", {15'h0000, useb}, {15'h0000, rows[i].exp_b});
      chk("mode", 16'({win, sgb, sga}), 16'(rows[i].spc[7:4]));
    end
    // Prefix lasts one instruction only
    sfr_acc(1'b1, dpu_pkg::ADDR_PCFG, 8'h00);
    cpu.issue(1'b1, dpu_pkg::OP_LOAD, 16'h4444, 8'h00);
    cpu.issue(1'b0, dpu_pkg::OP_INC, 16'h0000, 8'h00);
    rd16(dpu_pkg::ADDR_PTR1_LO, w);
    chk("pre_load", w, 16'h4444);
    rd16(dpu_pkg::ADDR_PTR0_LO, w);
    chk("plain_inc", w, 16'h12f1);
    for (int j = 0; j < 4; j++)
    begin
      sfr_acc(1'b1, dpu_pkg::ADDR_PCFG, {7'h00, j[1]});
      sfr_acc(1'b1, dpu_pkg::ADDR_SPC, j[0] ? (j[1] ? 8'h08 : 8'h04) : 8'h00);
      cpu.issue(1'b0, dpu_pkg::OP_LOAD, rng[j[1]].end_addr, 8'h00);
      cpu.issue(1'b0, dpu_pkg::OP_INC, 16'h0000, 8'h00);
      rd16(j[1] ? dpu_pkg::ADDR_PTR1_LO : dpu_pkg::ADDR_PTR0_LO, w);
      ea = j[0] ? rng[j[1]].start_addr : rng[j[1]].end_addr + 16'h0001;
      chk("circ", w, ea);
    end
    // Mid-run reset clears pointers, both configuration registers and the flags
    @(negedge mclk_in);
    srst_in = 1'b1;
    @(negedge mclk_in);
    srst_in = 1'b0;
    chk("out_rst2", addr | {valid, psel, useb, sga, sgb, win, 9'h000}, 16'h0000);
    rd16(dpu_pkg::ADDR_PTR1_LO, w);
    chk("ptr1_rst", w, 16'h0000);
    sfr_acc(1'b0, dpu_pkg::ADDR_PCFG, 8'h00);
    chk("pcfg_rst", {8'h00, rd_b}, 16'h0000);
    sfr_acc(1'b0, dpu_pkg::ADDR_SPC, 8'h00);
    chk("spc_rst2", {8'h00, rd_b}, 16'h0000);
    complete_run;
  end
endmodule
